// ### rtl/oms_ctrl.sv
// Purpose: mode selection, config check and key removal policy
// Assumes: key reader supplies settled authorisation levels
// Notes: stored mode input comes from external nonvolatile memory
//
// Summary of operation
// - capture switch at start, validate before use
// - any switch change while running means fault
// - only eight table settings are valid
// - settings five to eight select advanced download
// - lock and preselection only in advanced settings
// - policy follows setting pairs
// - hold and store keep mode on removal
// - fallback returns to mode one on removal
// - non-store policies start in mode one
// - store policy restores last selected mode
// - button two mode two, button one by hold
// - change only with key authorisation
// - removal behaviour selectable by switch
// - at most one mode output high at once
// - service by long hold of button one or by store restore
`timescale 1ns/1ns
`default_nettype none
module oms_ctrl
    import oms_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [3:0] cfg_switch, // configuration switch pins
    input wire logic button_one, // button one pin, high pressed
    input wire logic button_two, // button two pin, high pressed
    input wire logic key_inserted, // key present pin
    input wire logic key_auth_one, // key allows first_mode
    input wire logic key_auth_two, // key allows second_mode
    input wire logic key_auth_svc, // key allows service_mode
    input wire logic [1:0] stored_mode, // last mode from memory
    output logic mode_out_one, // monitored output first_mode
    output logic mode_out_two, // monitored output second_mode
    output logic mode_out_service, // monitored output service_mode
    output logic led_one, // backlight button one
    output logic led_two, // backlight button two
    output logic [1:0] mode_save, // mode to store
    output logic advanced_dl, // advanced download selected
    output logic lock_enable, // lock and preselection enabled
    output logic device_error // fault state
);
    logic [3:0] cfg_s; // synchronised switch
    logic b1_s; // synchronised button one
    logic b2_s; // synchronised button two
    oms_key_s key_s; // synchronised key levels

    // synchronisers for every pin except stored_mode
    for (genvar i = 0; i < 4; i++) begin : g_cfg
        oms_sync u_cfg (.sys_clk(sys_clk), .sys_rst(sys_rst),
            .pin_in(cfg_switch[i]), .sync_out(cfg_s[i]));
    end
    oms_sync u_b1 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pin_in(button_one), .sync_out(b1_s));
    oms_sync u_b2 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pin_in(button_two), .sync_out(b2_s));
    oms_sync u_ki (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pin_in(key_inserted), .sync_out(key_s.inserted));
    oms_sync u_k1 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pin_in(key_auth_one), .sync_out(key_s.auth_one));
    oms_sync u_k2 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pin_in(key_auth_two), .sync_out(key_s.auth_two));
    oms_sync u_k5 (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pin_in(key_auth_svc), .sync_out(key_s.auth_svc));

    // decode switch against the table
    oms_cfg_s dec; // decoded live setting
    always_comb begin
        dec = '0;
        for (int i = 0; i < NUM_SET; i++) begin
            if (cfg_s == CFG_TABLE[i]) begin
                dec.valid = 1'b1;
                dec.advanced = (i >= 4);
                dec.policy = oms_policy_e'(i[1:0]);
            end
        end
    end

    oms_state_e state_q, state_d; // control state
    logic [3:0] cfg_q, cfg_d; // captured setting
    oms_policy_e pol_q, pol_d; // captured policy
    logic adv_q, adv_d; // captured download mode
    oms_mode_e mode_q, mode_d; // current mode
    logic [CNT_W-1:0] hold_q, hold_d; // press duration
    logic b1_q, b2_q; // previous button levels
    logic key_q; // previous key level
    logic [FLASH_BIT:0] flash_q, flash_d; // flash divider
    logic restore_ok; // stored mode code is usable
    logic [1:0] settle_q, settle_d; // cycles waited in start
    logic settled; // pin chains show the pins

    assign restore_ok = (stored_mode != 2'b11);
    // synchronisers reset to zero, so capture only once they are full
    assign settled = (settle_q == 2'(START_WAIT));

    // next state of the controller
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        pol_d = pol_q;
        adv_d = adv_q;
        mode_d = mode_q;
        hold_d = hold_q;
        flash_d = flash_q + 1'b1;
        settle_d = settle_q;
        unique case (state_q)
            OMS_ST_START: begin
                if (!settled) begin
                    // pin chains still show their reset level
                    settle_d = settle_q + 1'b1;
                end else begin
                    cfg_d = cfg_s;
                    pol_d = dec.policy;
                    adv_d = dec.advanced;
                    if (!dec.valid) begin
                        state_d = OMS_ST_FAULT;
                    end else begin
                        state_d = OMS_ST_RUN;
                        if (dec.policy == OMS_POL_STORE && restore_ok) begin
                            mode_d = oms_mode_e'(stored_mode);
                        end else begin
                            mode_d = OMS_MODE_ONE;
                        end
                    end
                end
            end
            OMS_ST_RUN: begin
                if (cfg_s != cfg_q) begin
                    state_d = OMS_ST_FAULT;
                end else begin
                    // press duration of the single held button
                    if (b1_s ^ b2_s) begin
                        hold_d = (hold_q == '1) ? hold_q : hold_q + 1'b1;
                    end else begin
                        hold_d = '0;
                    end
                    // action on release of one button
                    if (b1_q && !b1_s && !b2_s && key_s.inserted &&
                        hold_q >= CNT_W'(MIN_PRESS_CYC)) begin
                        if (hold_q >= CNT_W'(SERVICE_HOLD_CYC)) begin
                            if (key_s.auth_svc) begin
                                mode_d = OMS_MODE_SVC;
                            end
                        end else if (key_s.auth_one) begin
                            mode_d = OMS_MODE_ONE;
                        end
                    end else if (b2_q && !b2_s && !b1_s &&
                        key_s.inserted && key_s.auth_two &&
                        hold_q >= CNT_W'(MIN_PRESS_CYC)) begin
                        mode_d = OMS_MODE_TWO;
                    end
                    // key removal policy
                    if (key_q && !key_s.inserted) begin
                        if (pol_q == OMS_POL_FALLBACK ||
                            (pol_q == OMS_POL_SVC_FB &&
                             mode_q == OMS_MODE_SVC)) begin
                            mode_d = OMS_MODE_ONE;
                        end else begin
                            mode_d = mode_q;
                        end
                    end
                end
            end
            OMS_ST_FAULT: begin
                state_d = OMS_ST_FAULT; // left only by reset
            end
            default: begin
                state_d = OMS_ST_FAULT; // illegal code
            end
        endcase
    end

    // register the controller
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= OMS_ST_START;
            cfg_q <= '0;
            pol_q <= OMS_POL_SVC_FB;
            adv_q <= 1'b0;
            mode_q <= MODE_RST;
            hold_q <= '0;
            b1_q <= 1'b0;
            b2_q <= 1'b0;
            key_q <= 1'b0;
            flash_q <= '0;
            settle_q <= '0;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            pol_q <= pol_d;
            adv_q <= adv_d;
            mode_q <= mode_d;
            hold_q <= hold_d;
            b1_q <= b1_s;
            b2_q <= b2_s;
            key_q <= key_s.inserted;
            flash_q <= flash_d;
            settle_q <= settle_d;
        end
    end

    // registered outputs from next values
    logic run_d; // running after this edge
    always_comb begin
        run_d = (state_d == OMS_ST_RUN);
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_out_one <= 1'b0;
            mode_out_two <= 1'b0;
            mode_out_service <= 1'b0;
            led_one <= 1'b0;
            led_two <= 1'b0;
            mode_save <= 2'b00;
            advanced_dl <= 1'b0;
            lock_enable <= 1'b0;
            device_error <= 1'b0;
        end else begin
            mode_out_one <= run_d && mode_d == OMS_MODE_ONE;
            mode_out_two <= run_d && mode_d == OMS_MODE_TWO;
            mode_out_service <= run_d && mode_d == OMS_MODE_SVC;
            led_one <= run_d && (mode_d == OMS_MODE_ONE ||
                (mode_d == OMS_MODE_SVC && flash_d[FLASH_BIT]));
            led_two <= run_d && (mode_d == OMS_MODE_TWO ||
                (mode_d == OMS_MODE_SVC && flash_d[FLASH_BIT]));
            mode_save <= mode_d;
            advanced_dl <= run_d && adv_d;
            lock_enable <= run_d && adv_d;
            device_error <= (state_d == OMS_ST_FAULT);
        end
    end

    // checks
    sequence key_pull_s;
        key_q && !key_s.inserted && state_q == OMS_ST_RUN &&
            cfg_s == cfg_q;
    endsequence
    one_hot_out_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $onehot0({mode_out_one, mode_out_two, mode_out_service}))
        else $error("more than one mode output high");
    cfg_change_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == OMS_ST_RUN && cfg_s != cfg_q |=> ##0 device_error
        ##1 device_error[*3])
        else $error("switch change did not fault");
    bad_cfg_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == OMS_ST_START && settled && !dec.valid |=> device_error)
        else $error("invalid setting accepted");
    fallback_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        key_pull_s ##0 (pol_q == OMS_POL_FALLBACK) |=> mode_out_one)
        else $error("fallback did not select mode one");
    hold_keep_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        key_pull_s ##0 (pol_q == OMS_POL_HOLD) |=> mode_q ==
        $past(mode_q))
        else $error("hold policy lost the mode");
    start_one_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == OMS_ST_START && settled && dec.valid &&
        dec.policy != OMS_POL_STORE |=> mode_out_one)
        else $error("start not in mode one");
    restore_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == OMS_ST_START && settled && dec.valid && restore_ok &&
        dec.policy == OMS_POL_STORE |=> mode_q == $past(stored_mode))
        else $error("stored mode not restored");
    auth_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == OMS_ST_RUN && mode_d != mode_q &&
        key_s.inserted |-> (mode_d == OMS_MODE_TWO && key_s.auth_two) ||
        (mode_d == OMS_MODE_ONE && key_s.auth_one) ||
        (mode_d == OMS_MODE_SVC && key_s.auth_svc))
        else $error("mode change without authorisation");
    lock_adv_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        lock_enable |-> adv_q && state_q == OMS_ST_RUN)
        else $error("lock enabled outside advanced setting");
endmodule : oms_ctrl
`default_nettype wire

// ### rtl/oms_pkg.sv
// Purpose: shared constants and types of the operating mode selector
// Assumes: 100 MHz system clock
// Notes: switch patterns of the eight valid settings are a table here
package oms_pkg;

    // clock rate and derived cycle counts
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned MIN_PRESS_MS = 50;
    localparam int unsigned SERVICE_HOLD_MS = 2000;
    localparam int unsigned MIN_PRESS_CYC = MIN_PRESS_MS * 1000 * CLK_MHZ;
    localparam int unsigned SERVICE_HOLD_CYC =
        SERVICE_HOLD_MS * 1000 * CLK_MHZ;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned CFG_W = 4;
    localparam int unsigned NUM_SET = 8;

    // switch pattern of each valid setting, index 0 is setting one
    localparam logic [CFG_W-1:0] CFG_TABLE [NUM_SET] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb
    };

    // flash divider for all buttons during service mode
    localparam int unsigned FLASH_BIT = 24;

    // cycles the start state waits for the pin chains to fill
    localparam int unsigned START_WAIT = 2;

    // key removal policy
    typedef enum logic [1:0] {
        OMS_POL_SVC_FB = 2'b00,
        OMS_POL_HOLD = 2'b01,
        OMS_POL_FALLBACK = 2'b10,
        OMS_POL_STORE = 2'b11
    } oms_policy_e;

    // operating mode
    typedef enum logic [1:0] {
        OMS_MODE_ONE = 2'b00,
        OMS_MODE_TWO = 2'b01,
        OMS_MODE_SVC = 2'b10
    } oms_mode_e;

    // main control state
    typedef enum logic [1:0] {
        OMS_ST_START = 2'b00,
        OMS_ST_RUN = 2'b01,
        OMS_ST_FAULT = 2'b10
    } oms_state_e;

    // key authorisation
    typedef struct packed {
        logic inserted;
        logic auth_one;
        logic auth_two;
        logic auth_svc;
    } oms_key_s;

    // decoded configuration
    typedef struct packed {
        logic valid;
        logic advanced;
        oms_policy_e policy;
    } oms_cfg_s;

    localparam oms_mode_e MODE_RST = OMS_MODE_ONE;

endpackage : oms_pkg

// ### rtl/oms_sync.sv
// Purpose: two flip-flop synchroniser for one pin input
// Assumes: input is asynchronous to sys_clk
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module oms_sync (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic pin_in, // raw pin
    output logic sync_out // synchronised level
);
    logic meta_q; // first stage
    logic meta_d; // next first stage
    logic sync_d; // next second stage

    // next values
    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
    end

    // register both stages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule : oms_sync
`default_nettype wire

// ### tb/oms_safety_mon.sv
// Purpose: safety controller model reading the three mode outputs
// Assumes: mode outputs are registered on sys_clk
// Notes: flags any cycle with more than one mode output high
`timescale 1ns/1ns
`default_nettype none
module oms_safety_mon (
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic mode_out_one, // first_mode output
    input wire logic mode_out_two, // second_mode output
    input wire logic mode_out_service, // service_mode output
    output logic multi_err // sticky one-of-n violation
);
    // one-of-n evaluation, sticky until reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            multi_err <= 1'b0;
        end else if (({1'b0, mode_out_one} + {1'b0, mode_out_two}
                + {1'b0, mode_out_service}) > 2'h1) begin
            multi_err <= 1'b1;
        end
    end
endmodule : oms_safety_mon
`default_nettype wire

// ### tb/oms_ctrl_tb_top.sv
// Purpose: self-checking bench of the mode selector control
// Assumes: long press times are not reachable in a short run
// Notes: settings table, switch change, key removal, short press
`timescale 1ns/1ns
`default_nettype none
module oms_ctrl_tb_top;
    import oms_pkg::*;
    logic sys_clk = 1'b0; // bench clock
    logic sys_rst = 1'b1; // bench reset
    logic [3:0] cfg_switch = 4'h0; // switch pins
    logic button_one = 1'b0, button_two = 1'b0; // buttons
    logic key_inserted = 1'b0, key_auth_one = 1'b0; // key pins
    logic key_auth_two = 1'b0, key_auth_svc = 1'b0; // key pins
    logic [1:0] stored_mode = 2'h1; // remembered mode
    logic mode_out_one, mode_out_two, mode_out_service; // outputs
    logic led_one, led_two, advanced_dl, lock_enable, device_error;
    logic [1:0] mode_save; // mode to store
    logic multi_err; // partner verdict
    int n_errors = 0; // mismatches
    int checks = 0; // comparisons
    int cyc = 0; // timeout counter

    oms_ctrl oms_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cfg_switch(cfg_switch), .button_one(button_one),
        .button_two(button_two), .key_inserted(key_inserted),
        .key_auth_one(key_auth_one), .key_auth_two(key_auth_two),
        .key_auth_svc(key_auth_svc), .stored_mode(stored_mode),
        .mode_out_one(mode_out_one), .mode_out_two(mode_out_two),
        .mode_out_service(mode_out_service), .led_one(led_one),
        .led_two(led_two), .mode_save(mode_save),
        .advanced_dl(advanced_dl), .lock_enable(lock_enable),
        .device_error(device_error));
    oms_safety_mon oms_safety_mon_i (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .mode_out_one(mode_out_one),
        .mode_out_two(mode_out_two),
        .mode_out_service(mode_out_service), .multi_err(multi_err));

    // clock, 10 ns period
    always #5 sys_clk = ~sys_clk;

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end

    // compare one value and count it
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
            input string what);
        checks = checks + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen,
                exp);
        end
    endtask : chk

    // mode outputs as {service, two, one} plus partner verdict
    task automatic mode_is(input logic [2:0] exp);
        chk({5'h0, mode_out_service, mode_out_two, mode_out_one},
            {5'h0, exp}, "mode outputs");
        chk({7'h0, multi_err}, 8'h0, "one of n");
    endtask : mode_is

    // reset 16 cycles with the given switch and stored mode
    task automatic boot(input logic [3:0] cfg, input logic [1:0] sm);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        cfg_switch <= cfg;
        stored_mode <= sm;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
    endtask : boot

    // every switch pattern: validity, download mode, start mode
    task automatic t_settings();
        int idx;
        logic store;
        for (int p = 0; p < 16; p++) begin
            idx = -1;
            for (int i = 0; i < NUM_SET; i++) begin
                if (CFG_TABLE[i] == p[3:0]) idx = i;
            end
            store = (idx >= 0) && (idx % 4 == 3);
            boot(p[3:0], 2'h1);
            chk({7'h0, device_error}, {7'h0, idx < 0}, "fault");
            chk({7'h0, advanced_dl}, {7'h0, idx >= 4}, "adv");
            chk({7'h0, lock_enable}, {7'h0, idx >= 4}, "lock");
            if (idx < 0) begin
                mode_is(3'h0);
            end else if (store) begin
                mode_is(3'h2);
                chk({6'h0, led_two, led_one}, 8'h2, "leds");
                chk({6'h0, mode_save}, 8'h1, "save");
            end else begin
                mode_is(3'h1);
                chk({6'h0, led_two, led_one}, 8'h1, "leds");
            end
        end
        $display("test settings done");
    endtask : t_settings

    // switch moved while running
    task automatic t_change();
        boot(CFG_TABLE[0], 2'h0);
        @(posedge sys_clk);
        cfg_switch <= CFG_TABLE[1];
        repeat (8) @(posedge sys_clk);
        #1;
        chk({7'h0, device_error}, 8'h1, "change fault");
        mode_is(3'h0);
        $display("test change done");
    endtask : t_change

    // service restored under storage, kept on key removal
    task automatic t_removal();
        @(posedge sys_clk);
        key_inserted <= 1'b1;
        key_auth_svc <= 1'b1;
        boot(CFG_TABLE[7], 2'h2);
        mode_is(3'h4);
        chk({6'h0, led_two, led_one}, 8'h0, "flash off");
        chk({6'h0, mode_save}, 8'h2, "save svc");
        @(posedge sys_clk);
        key_inserted <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        mode_is(3'h4);
        chk({7'h0, device_error}, 8'h0, "no fault");
        $display("test removal done");
    endtask : t_removal

    // key pulled in mode one under service fallback, hold, fallback
    task automatic t_pull();
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            key_inserted <= 1'b1;
            key_auth_one <= 1'b1;
            boot(CFG_TABLE[i], 2'h1);
            mode_is(3'h1);
            @(posedge sys_clk);
            key_inserted <= 1'b0;
            repeat (8) @(posedge sys_clk);
            #1;
            mode_is(3'h1);
            chk({6'h0, led_two, led_one}, 8'h1, "pull leds");
            chk({7'h0, device_error}, 8'h0, "pull no fault");
        end
        $display("test key pull done");
    endtask : t_pull

    // short press with first and second mode authorisation changes nothing
    task automatic t_short();
        @(posedge sys_clk);
        key_inserted <= 1'b1;
        key_auth_one <= 1'b1;
        key_auth_two <= 1'b1;
        boot(CFG_TABLE[5], 2'h0);
        @(posedge sys_clk);
        button_two <= 1'b1;
        repeat (100) @(posedge sys_clk);
        button_two <= 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
        mode_is(3'h1);
        chk({6'h0, mode_save}, 8'h0, "save");
        $display("test short press done");
    endtask : t_short

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        t_settings();
        t_change();
        t_removal();
        t_pull();
        t_short();
        results();
    end
endmodule : oms_ctrl_tb_top
`default_nettype wire
